// >>> sbsr_pkg.sv
// How it works
// - Bit 0 is masked measure event summary.
// - Bit 1 is masked source event summary.
// - Bit 2 follows error queue not empty.
// - Bit 4 follows output queue not empty.
// - Bit 5 is masked standard event summary.
// - Master summary is AND with service enable.
// - Request flag rises with summary, clears otherwise.
// - Service request output follows bit 6.
// - Zero service enable bit masks that bit.
// - Status query shows master summary, clears nothing.
// - Serial poll shows request flag, clears it.
// - Clear status clears events, keeps message bit.
// - Clear after terminator also empties output queue.
// - No forced clear of whole status byte.
// - Power on flag set at power up.
// - User request flag always zero.
// - Syntax error sets event bit 5.
// - Execution error sets event bit 4.
// - Device fault sets event bit 3.
// - Query error sets event bit 2.
// - Event enable written and read back.
// - Request control flag always zero.
// - Operation complete sets event bit 0.
// - Event read, clear status, power up clear.
package sbsr_pkg;
    localparam int SB_MEASURE = 0;
    localparam int SB_SOURCE  = 1;
    localparam int SB_ERROR   = 2;
    localparam int SB_MESSAGE = 4;
    localparam int SB_EVENT   = 5;
    localparam int SB_SUMMARY = 6;
    localparam int EV_OPERATION    = 0;
    localparam int EV_REQUEST_CTRL = 1;
    localparam int EV_QUERY   = 2;
    localparam int EV_DEVICE  = 3;
    localparam int EV_EXEC    = 4;
    localparam int EV_SYNTAX  = 5;
    localparam int EV_USER_REQUEST = 6;
    localparam int EV_POWER_ON     = 7;
    localparam logic [7:0] EVENT_RESET  = 8'h80;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] EVENT_USED   = 8'hBD;
endpackage

// >>> sbsr_evt_if.sv
`timescale 1ns/1ps
interface sbsr_evt_if;
    logic [7:0] set_bits;
    logic       clr;
    logic [7:0] flags;
    modport ctl (output set_bits, output clr, input flags);
    modport reg_side (input set_bits, input clr, output flags);
endinterface

// >>> sbsr_event_reg.sv
`timescale 1ns/1ps
module sbsr_event_reg
    import sbsr_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    sbsr_evt_if.reg_side ev
);
    logic [7:0] flags_reg;
    // Set wins over clear so an event in the clearing cycle survives.
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_reg <= EVENT_RESET;
        end else if (ce) begin
            flags_reg <= ((ev.clr ? 8'h00 : flags_reg) | ev.set_bits) & EVENT_USED;
        end
    end
    assign ev.flags = flags_reg;
endmodule // sbsr_event_reg

// >>> sbsr_top.sv
`timescale 1ns/1ps
module sbsr_top
    import sbsr_pkg::*;
#(
    parameter int WIDTH = 8
)(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] measure_event,
    input  wire logic [WIDTH-1:0] measure_enable,
    input  wire logic [WIDTH-1:0] source_event,
    input  wire logic [WIDTH-1:0] source_enable,
    input  wire logic             error_queue_not_empty,
    input  wire logic             output_queue_not_empty,
    input  wire logic             syntax_error,
    input  wire logic             execution_error,
    input  wire logic             device_fault,
    input  wire logic             query_error,
    input  wire logic             operation_complete,
    input  wire logic             event_enable_command,
    input  wire logic [7:0]       event_enable_data,
    input  wire logic             service_enable_command,
    input  wire logic [7:0]       service_enable_data,
    input  wire logic             clear_status_command,
    input  wire logic             after_terminator,
    input  wire logic             event_status_query,
    input  wire logic             status_byte_query,
    input  wire logic             serial_poll,
    output logic      [7:0]       event_enable_q,
    output logic      [7:0]       service_enable_q,
    output logic      [7:0]       event_status_q,
    output logic      [7:0]       status_byte_q,
    output logic      [7:0]       poll_byte_q,
    output logic                  answer_valid,
    output logic                  service_request,
    output logic                  source_clear,
    output logic                  output_queue_flush
);
    // The width limit keeps the reduction trees within what the summary inputs may carry.
    if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
        $error("WIDTH out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    sbsr_evt_if ev ();
    logic [7:0] event_enable_reg;
    logic [7:0] service_enable_reg;
    logic [7:0] sb;
    logic       master_summary;
    logic       master_summary_prev_reg;
    logic       request_service_flag_reg;

    // Bits 7, 6 and 1 have no set source; bits 6 and 1 always read zero, bit 7 is set only by reset.
    assign ev.set_bits = {1'b0, 1'b0, syntax_error, execution_error,
                          device_fault, query_error, 1'b0,
                          operation_complete};
    assign ev.clr = clear_status_command | event_status_query;

    sbsr_event_reg u_evt (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .ev   (ev)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            event_enable_reg <= ENABLE_RESET;
        end else if (ce && event_enable_command) begin
            event_enable_reg <= event_enable_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            service_enable_reg <= ENABLE_RESET;
        end else if (ce && service_enable_command) begin
            service_enable_reg <= service_enable_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The summaries are purely combinational; nothing is ever cleared here.
    always_comb begin
        sb = 8'h00;
        sb[SB_MEASURE] = |(measure_event & measure_enable);
        sb[SB_SOURCE]  = |(source_event & source_enable);
        sb[SB_ERROR]   = error_queue_not_empty;
        sb[SB_MESSAGE] = output_queue_not_empty;
        sb[SB_EVENT]   = |(ev.flags & event_enable_reg);
    end
    assign master_summary = |(sb & service_enable_reg);

    always_ff @(posedge mclk) begin
        if (rst) begin
            master_summary_prev_reg <= 1'b0;
        end else if (ce) begin
            master_summary_prev_reg <= master_summary;
        end
    end

    // A fresh rise beats a simultaneous poll so a new request is not lost.
    always_ff @(posedge mclk) begin
        if (rst) begin
            request_service_flag_reg <= 1'b0;
        end else if (ce) begin
            if (master_summary && !master_summary_prev_reg) begin
                request_service_flag_reg <= 1'b1;
            end else if (serial_poll || !master_summary) begin
                request_service_flag_reg <= 1'b0;
            end
        end
    end
    assign service_request = request_service_flag_reg;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_byte_q  <= 8'h00;
            poll_byte_q    <= 8'h00;
            event_status_q <= 8'h00;
            answer_valid   <= 1'b0;
        end else if (ce) begin
            answer_valid <= status_byte_query | serial_poll | event_status_query;
            if (status_byte_query) begin
                status_byte_q <= sb | {1'b0, master_summary, 6'h00};
            end
            if (serial_poll) begin
                poll_byte_q <= sb | {1'b0, request_service_flag_reg, 6'h00};
            end
            if (event_status_query) begin
                event_status_q <= ev.flags;
            end
        end
    end

    assign event_enable_q   = event_enable_reg;
    assign service_enable_q = service_enable_reg;
    assign source_clear     = ce & clear_status_command;
    // Only a clear right after a terminator may flush; otherwise the queue stays.
    assign output_queue_flush = ce & clear_status_command & after_terminator;

    ////////////////////////////////////////////////////////////////////////////
    property p_rise;
        @(posedge mclk) disable iff (rst)
            ce && master_summary && !master_summary_prev_reg |=> request_service_flag_reg;
    endproperty
    a_rise: assert property (p_rise) else $error("request flag missed rise");
    property p_fall;
        @(posedge mclk) disable iff (rst) ce && !master_summary |=> !request_service_flag_reg;
    endproperty
    a_fall: assert property (p_fall) else $error("request flag kept after fall");
    property p_poll;
        @(posedge mclk) disable iff (rst)
            ce && serial_poll && master_summary_prev_reg |=> !request_service_flag_reg;
    endproperty
    a_poll: assert property (p_poll) else $error("poll did not clear flag");
    property p_master_summary;
        @(posedge mclk) disable iff (rst) master_summary ==
            ((|(measure_event & measure_enable) && service_enable_reg[SB_MEASURE])
            || (|(source_event & source_enable) && service_enable_reg[SB_SOURCE])
            || (error_queue_not_empty && service_enable_reg[SB_ERROR])
            || (output_queue_not_empty && service_enable_reg[SB_MESSAGE])
            || (|(ev.flags & event_enable_reg) && service_enable_reg[SB_EVENT]));
    endproperty
    a_master_summary: assert property (p_master_summary) else $error("master summary wrong");
    property p_status_query;
        @(posedge mclk) disable iff (rst) ce && status_byte_query |=>
            status_byte_q[SB_SUMMARY] == $past(master_summary) && answer_valid;
    endproperty
    a_status_query: assert property (p_status_query) else $error("status query bit 6 wrong");
    property p_poll_byte;
        @(posedge mclk) disable iff (rst) ce && serial_poll |=>
            poll_byte_q[SB_SUMMARY] == $past(request_service_flag_reg) && answer_valid;
    endproperty
    a_poll_byte: assert property (p_poll_byte) else $error("poll bit 6 wrong");
    property p_evt_clr;
        @(posedge mclk) disable iff (rst) ce && clear_status_command && ev.set_bits == 8'h00
            |=> ev.flags == 8'h00 && !sb[SB_EVENT];
    endproperty
    a_evt_clr: assert property (p_evt_clr) else $error("clear status left events");
    property p_event_query;
        @(posedge mclk) disable iff (rst) ce && event_status_query && ev.set_bits == 8'h00
            |=> ev.flags == 8'h00;
    endproperty
    a_event_query: assert property (p_event_query) else $error("event read kept flags");
    property p_power_on;
        @(posedge mclk) rst |=> ev.flags == EVENT_RESET;
    endproperty
    a_power_on: assert property (p_power_on) else $error("power on flag not set");
    property p_zero;
        @(posedge mclk) disable iff (rst)
            !ev.flags[EV_USER_REQUEST] && !ev.flags[EV_REQUEST_CTRL];
    endproperty
    a_zero: assert property (p_zero) else $error("unused event bit set");
    property p_set;
        @(posedge mclk) disable iff (rst) ce && syntax_error |=> ev.flags[EV_SYNTAX];
    endproperty
    a_set: assert property (p_set) else $error("syntax error not recorded");
    property p_flush;
        @(posedge mclk) disable iff (rst)
            output_queue_flush == (ce && clear_status_command && after_terminator);
    endproperty
    a_flush: assert property (p_flush) else $error("flush without terminator");
    c_rise: cover property (@(posedge mclk) disable iff (rst)
        !request_service_flag_reg ##1 request_service_flag_reg);
    c_poll: cover property (@(posedge mclk) disable iff (rst)
        request_service_flag_reg && serial_poll);
    c_clear_status: cover property (@(posedge mclk) disable iff (rst) clear_status_command);
endmodule // sbsr_top

// >>> sbsr_ctl_model.sv
`timescale 1ns/1ps
module sbsr_ctl_model (
    input  wire logic mclk,
    output logic      status_byte_query,
    output logic      serial_poll,
    output logic      event_status_query,
    output logic      clear_status_command,
    output logic      after_terminator
);
    logic [4:0] req = 5'h00;
    assign {status_byte_query, serial_poll, event_status_query} = req[4:2];
    assign {clear_status_command, after_terminator} = req[1:0];
    ////////////////////////////////////////
    // One strobe cycle per request, raised just past an edge; the task returns
    // just past the edge that registers the answer, so it can be read at once.
    task automatic send(input logic [4:0] s);
        req = s;
        @(posedge mclk);
        #1;
        req = 5'h00;
    endtask
endmodule // sbsr_ctl_model

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module tb_top;
    import sbsr_pkg::*;
    typedef struct packed {
        logic [7:0] me, men, se, sen;
        logic       eq, oq;
        logic [7:0] srv_en, sb;
    } sbsr_row_t;
    logic       mclk, rst, ce, error_queue_not_empty, output_queue_not_empty;
    logic [7:0] measure_event, measure_enable, source_event, source_enable;
    logic       syntax_error, execution_error, device_fault, query_error;
    logic       operation_complete, event_enable_command, service_enable_command;
    logic [7:0] event_enable_data, service_enable_data, event_enable_q, service_enable_q;
    logic [7:0] event_status_q, status_byte_q, poll_byte_q;
    logic       status_byte_query, serial_poll, event_status_query;
    logic       clear_status_command, after_terminator, answer_valid;
    logic       service_request, source_clear, output_queue_flush;
    int         fail_count = 0;
    int         compares = 0;
    int         cycles = 0;
    sbsr_row_t  rows [7] = '{
        '{8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'hFF, 8'h00},
        '{8'h01, 8'h01, 8'h00, 8'h00, 1'b0, 1'b0, 8'hFF, 8'h41},
        '{8'hF0, 8'h0F, 8'h02, 8'h02, 1'b0, 1'b0, 8'hFF, 8'h42},
        '{8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h04, 8'h44},
        '{8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'hFB, 8'h04},
        '{8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 8'h10, 8'h50},
        '{8'h80, 8'h80, 8'h01, 8'h01, 1'b1, 1'b1, 8'h00, 8'h17}};
    sbsr_top sbsr_top_inst (.mclk, .rst, .ce, .measure_event, .measure_enable,
        .source_event, .source_enable, .error_queue_not_empty, .output_queue_not_empty,
        .syntax_error, .execution_error, .device_fault, .query_error, .operation_complete,
        .event_enable_command, .event_enable_data, .service_enable_command,
        .service_enable_data, .clear_status_command, .after_terminator,
        .event_status_query, .status_byte_query, .serial_poll, .event_enable_q,
        .service_enable_q, .event_status_q, .status_byte_q, .poll_byte_q, .answer_valid,
        .service_request, .source_clear, .output_queue_flush);
    sbsr_ctl_model sbsr_ctl_model_inst (.mclk, .status_byte_query, .serial_poll,
        .event_status_query, .clear_status_command, .after_terminator);
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic ask(input logic [4:0] s);
        sbsr_ctl_model_inst.send(s);
        @(posedge mclk);
        #1;
    endtask
    // Enable is dropped to zero first so every row whose summary is set gives a fresh summary rise.
    task automatic run_row(input sbsr_row_t r);
        {measure_event, measure_enable, source_event, source_enable} = r[49:18];
        {error_queue_not_empty, output_queue_not_empty} = {r.eq, r.oq};
        {service_enable_command, service_enable_data} = 9'h100;
        @(posedge mclk);
        #1;
        service_enable_data = r.srv_en;
        @(posedge mclk);
        #1;
        service_enable_command = 0;
        `CHK(service_enable_q, r.srv_en)
        ask(5'h10);
        `CHK(status_byte_q, r.sb)
        `CHK(service_request, r.sb[6])
        ask(5'h08);
        `CHK(poll_byte_q, r.sb)
        `CHK(service_request, 1'b0)
    endtask
    ////////////////////////////////////////
    initial begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        {rst, ce} = 2'b11;
        {measure_event, measure_enable, source_event, source_enable} = 32'h0;
        {error_queue_not_empty, output_queue_not_empty} = 2'b00;
        {syntax_error, execution_error, device_fault, query_error} = 4'h0;
        {operation_complete, event_enable_command, service_enable_command} = 3'h0;
        {event_enable_data, service_enable_data} = 16'h0;
        repeat (5) @(posedge mclk);
        #1;
        rst = 0;
        `CHK({event_enable_q, service_enable_q, service_request}, 17'h0)
        foreach (rows[i]) run_row(rows[i]);
        {event_enable_command, event_enable_data} = 9'h1FF;
        @(posedge mclk);
        #1;
        event_enable_command = 0;
        `CHK(event_enable_q, 8'hFF)
        {syntax_error, execution_error, device_fault, query_error} = 4'hF;
        operation_complete = 1;
        @(posedge mclk);
        #1;
        {syntax_error, execution_error, device_fault, query_error} = 4'h0;
        operation_complete = 0;
        ask(5'h10);
        `CHK(status_byte_q, 8'h37)
        ask(5'h04);
        `CHK(event_status_q, 8'hBD)
        ask(5'h04);
        `CHK(event_status_q, 8'h00)
        syntax_error = 1;
        @(posedge mclk);
        #1;
        syntax_error = 0;
        fork
            ask(5'h02);
            #1 `CHK({source_clear, output_queue_flush}, 2'b10)
        join
        ask(5'h10);
        `CHK(status_byte_q, 8'h17)
        fork
            ask(5'h03);
            #1 `CHK(output_queue_flush, 1'b1)
        join
        // With the enable low a query and a write must be ignored; the level change shows at the next enabled query.
        ce = 0;
        error_queue_not_empty = 0;
        {event_enable_command, event_enable_data} = 9'h100;
        sbsr_ctl_model_inst.send(5'h10);
        `CHK(answer_valid, 1'b0)
        `CHK({status_byte_q, event_enable_q}, 16'h17FF)
        event_enable_command = 0;
        ce = 1;
        sbsr_ctl_model_inst.send(5'h10);
        `CHK(answer_valid, 1'b1)
        `CHK(status_byte_q, 8'h13)
        rst = 1;
        @(posedge mclk);
        #1;
        rst = 0;
        `CHK({event_enable_q, service_enable_q, service_request}, 17'h0)
        ask(5'h04);
        `CHK(event_status_q, 8'h80)
        wrap_up();
    end
endmodule // tb_top
